// ### cfrs_pkg.sv
// cfrs_pkg: constants and types shared by both ends of the core-first reset sequence.
// assumes a single 125 MHz clock at both ends.
package cfrs_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS     = 8000;
	localparam int STAB_HOLD_US      = 100;
	localparam int STAB_HOLD_CYC     = (STAB_HOLD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int REF_PERIODS_INIT  = 500;
	localparam int REF_PERIOD_MAX_PS = 33330;
	localparam int INIT_WAIT_CYC     =
		(REF_PERIODS_INIT * REF_PERIOD_MAX_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FULL_LOW_EDGES    = 24;
	localparam int CFG_SETUP_EDGES   = 12;
	localparam int CFG_HOLD_EDGES    = 12;
	localparam int STAT_MIN_CYC      = 10000;
	localparam int STAT_MAX_CYC      = 50000;
	localparam int CNT_W             = 24;
	localparam int CFG_W             = 16;

	// ------------------------------------------------------------
	// device states
	// ------------------------------------------------------------
	typedef enum logic [3:0]
	{
		CFRS_D_POR  = 4'b0001,
		CFRS_D_HOLD = 4'b0010,
		CFRS_D_SCAN = 4'b0100,
		CFRS_D_DONE = 4'b1000
	} cfrs_dev_st_t;

	// ------------------------------------------------------------
	// supervisor states
	// ------------------------------------------------------------
	typedef enum logic [7:0]
	{
		CFRS_S_OFF   = 8'b0000_0001,
		CFRS_S_CORE  = 8'b0000_0010,
		CFRS_S_IO    = 8'b0000_0100,
		CFRS_S_STAB  = 8'b0000_1000,
		CFRS_S_INIT  = 8'b0001_0000,
		CFRS_S_FULL  = 8'b0010_0000,
		CFRS_S_HOLD  = 8'b0100_0000,
		CFRS_S_RUN   = 8'b1000_0000
	} cfrs_sup_st_t;

	// saturating counter step, used by both ends
	function automatic logic [CNT_W-1:0] cfrs_inc(input logic [CNT_W-1:0] v);
		cfrs_inc = (v == {CNT_W{1'b1}}) ? v : v + 24'h00_0001;
	endfunction

endpackage

// ### cfrs_if.sv
// cfrs_if: board-level reset and supply pins between supervisor and device.
// assumes both ends share the testbench clock; pins are plain levels.
`timescale 1ns/1ns
interface cfrs_if;
	import cfrs_pkg::*;
	logic             core_supply_ok;
	logic             memory_array_supply_ok;
	logic             io_supply_1v8_ok;
	logic             io_supply_1v5_en;
	logic             pll_reference_clock_run;
	logic             memory_reference_clock_run;
	logic             por_n;
	logic             full_reset_in_n;
	logic             warm_reset_n;
	logic [CFG_W-1:0] boot_cfg;
	logic             reset_status_out;

	modport sup
	(
		output core_supply_ok, memory_array_supply_ok, io_supply_1v8_ok, io_supply_1v5_en,
		output pll_reference_clock_run, memory_reference_clock_run,
		output por_n, full_reset_in_n, warm_reset_n, boot_cfg,
		input  reset_status_out
	);
	modport dev
	(
		input  core_supply_ok, memory_array_supply_ok, io_supply_1v8_ok, io_supply_1v5_en,
		input  pll_reference_clock_run, memory_reference_clock_run,
		input  por_n, full_reset_in_n, warm_reset_n, boot_cfg,
		output reset_status_out
	);
endinterface

// ### cfrs_sup.sv
// cfrs_sup: board supervisor, sequences rails, clocks, resets and boot straps.
// assumes the device end answers on reset_status_out; all link inputs are
// synchronised here.
// limitation: straps are taken from BOOT_CFG_I once, as por rises; a later
// change waits for the next sequence after reset.
// a missing status only raises TIMEOUT_O; the sequence is not retried.
//
// Notes on behaviour
// - por held low through supply stabilisation
// - por low 100 us after supplies stable
// - 500 slow reference periods before por rises
// - reference clock runs before por release
// - full reset low 24 edges after por
// - full reset low time may be extended
// - por released before full reset released
// - device latches boot bits on full rise
// - boot bits valid 12 edges before rise
// - boot bits held 12 edges after rise
// - full rise starts device fuse scan
// - status high 10000 to 50000 cycles later
// - status low while 1v8 supply absent
// - warm reset high before por rises
// - reference clocks start after core supply
// - 1v5 supply only after 1v8 valid
// - short gaps between rail steps
`timescale 1ns/1ns
module cfrs_sup
	import cfrs_pkg::*;
(
	// clock and reset
	input  wire logic             CLOCK_I,
	input  wire logic             NRST_I,
	// user control
	input  wire logic             START_I,
	input  wire logic [CNT_W-1:0] EXTRA_HOLD_I,
	input  wire logic [CFG_W-1:0] BOOT_CFG_I,
	// status
	output logic                  DEVICE_READY_O,
	output logic                  TIMEOUT_O,
	// link
	cfrs_if.sup                   link
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed
	{
		cfrs_sup_st_t     st;
		logic [CNT_W-1:0] cnt;
		logic [1:0]       stat_sync;
		logic             core_ok;
		logic             io18_ok;
		logic             io15_en;
		logic             clk_run;
		logic             por_n;
		logic             full_n;
		logic             warm_n;
		logic [CFG_W-1:0] cfg;
		logic             ready;
		logic             timeout;
	} cfrs_sup_s_t;

	cfrs_sup_s_t s_q;
	cfrs_sup_s_t s_d;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// true once a phase counter has covered the wanted number of cycles;
	// one rising edge per cycle; stab and init last exactly their minimum, full and hold one cycle past their limit
	function automatic logic reached(input logic [CNT_W-1:0] cnt,
		input logic [CNT_W-1:0] lim);
		reached = (cnt >= lim);
	endfunction

	// full reset low time: the fixed minimum plus whatever the user asks for
	logic [CNT_W-1:0] full_lim;

	assign full_lim = CNT_W'(FULL_LOW_EDGES + CFG_SETUP_EDGES) + EXTRA_HOLD_I;

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		s_d           = s_q;
		s_d.stat_sync = {s_q.stat_sync[0], link.reset_status_out};
		s_d.cnt       = cfrs_inc(s_q.cnt);
		unique case (s_q.st)
			CFRS_S_OFF:
			begin
				// START_I counts only here; it is ignored until the next reset
				if (START_I)
				begin
					s_d.core_ok = 1'b1;
					s_d.st      = CFRS_S_CORE;
					s_d.cnt     = '0;
				end
			end
			CFRS_S_CORE:
			begin
				// clocks only once core rail is valid
				s_d.clk_run = 1'b1;
				s_d.io18_ok = 1'b1;
				s_d.st      = CFRS_S_IO;
			end
			CFRS_S_IO:
			begin
				// 1v5 one cycle after 1v8, far inside any gap limit
				s_d.io15_en = 1'b1;
				s_d.warm_n  = 1'b1;
				s_d.st      = CFRS_S_STAB;
				s_d.cnt     = '0;
			end
			CFRS_S_STAB:
			begin
				// all rails are up here; por stays low for the hold
				if (reached(s_q.cnt, CNT_W'(STAB_HOLD_CYC - 1)))
				begin
					s_d.st  = CFRS_S_INIT;
					s_d.cnt = '0;
				end
			end
			CFRS_S_INIT:
			begin
				// por still low; clock already running
				if (reached(s_q.cnt, CNT_W'(INIT_WAIT_CYC - 1)) && s_q.clk_run)
				begin
					// straps taken once, so a late change of BOOT_CFG_I cannot
					// break the setup window before full reset rises
					s_d.cfg   = BOOT_CFG_I;
					s_d.por_n = 1'b1;
					s_d.st    = CFRS_S_FULL;
					s_d.cnt   = '0;
				end
			end
			CFRS_S_FULL:
			begin
				// straps already stand on the pins; the low time covers
				// both the reset minimum and their setup window
				if (reached(s_q.cnt, full_lim))
				begin
					s_d.full_n = 1'b1;
					s_d.st     = CFRS_S_HOLD;
					s_d.cnt    = '0;
				end
			end
			CFRS_S_HOLD:
			begin
				// straps frozen past the hold window, then wait for status;
				// they stay frozen afterwards as well
				if (reached(s_q.cnt, CNT_W'(CFG_HOLD_EDGES)))
					s_d.st = CFRS_S_RUN;
			end
			CFRS_S_RUN:
			begin
				// status arrives through two flops; a missing status is
				// reported, not retried
				if (s_q.stat_sync[1])
					s_d.ready = 1'b1;
				else if (s_q.cnt > CNT_W'(STAT_MAX_CYC + 4))
					s_d.timeout = 1'b1;
			end
		endcase
		// every pin low in reset: rails off, clocks stopped, resets asserted
		if (!NRST_I)
		begin
			s_d.st        = CFRS_S_OFF;
			s_d.cnt       = '0;
			s_d.stat_sync = '0;
			s_d.core_ok   = 1'b0;
			s_d.io18_ok   = 1'b0;
			s_d.io15_en   = 1'b0;
			s_d.clk_run   = 1'b0;
			s_d.por_n     = 1'b0;
			s_d.full_n    = 1'b0;
			s_d.warm_n    = 1'b0;
			s_d.cfg       = '0;
			s_d.ready     = 1'b0;
			s_d.timeout   = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK_I)
		s_q <= s_d;

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// memory rail and memory clock track the core rail and the pll clock
	assign link.core_supply_ok             = s_q.core_ok;
	assign link.memory_array_supply_ok     = s_q.core_ok;
	assign link.io_supply_1v8_ok           = s_q.io18_ok;
	assign link.io_supply_1v5_en           = s_q.io15_en;
	assign link.pll_reference_clock_run    = s_q.clk_run;
	assign link.memory_reference_clock_run = s_q.clk_run;
	assign link.por_n                      = s_q.por_n;
	assign link.full_reset_in_n            = s_q.full_n;
	assign link.warm_reset_n               = s_q.warm_n;
	assign link.boot_cfg                   = s_q.cfg;
	assign DEVICE_READY_O                  = s_q.ready;
	assign TIMEOUT_O                       = s_q.timeout;

endmodule // cfrs_sup

// ### cfrs_dev.sv
// cfrs_dev: device end, latches boot straps and runs the fuse scan.
// assumes the supervisor keeps its sequencing; the por, full reset, 1v8 and
// strap pins pass two flip-flops; the other link inputs are unused.
`timescale 1ns/1ns
module cfrs_dev
	import cfrs_pkg::*;
#(
	parameter int SCAN_CYC = 20000
)
(
	// clock and reset
	input  wire logic             CLOCK_I,
	input  wire logic             NRST_I,
	// user side
	output logic [CFG_W-1:0]      BOOT_CFG_O,
	output logic                  FUSE_RESET_N_O,
	output logic                  CORE_RESET_N_O,
	// link
	cfrs_if.dev                   link
);
	typedef struct packed
	{
		cfrs_dev_st_t     st;
		logic [CNT_W-1:0] cnt;
		logic [1:0]       por_s;
		logic [1:0]       full_s;
		logic [1:0]       io18_s;
		logic [CFG_W-1:0] cfg_s1;
		logic [CFG_W-1:0] cfg_s2;
		logic             full_prev;
		logic [CFG_W-1:0] cfg;
		logic             fuse_n;
		logic             core_n;
		logic             stat;
	} cfrs_dev_s_t;

	cfrs_dev_s_t s_q;
	cfrs_dev_s_t s_d;

	always_comb
	begin
		s_d           = s_q;
		s_d.por_s     = {s_q.por_s[0], link.por_n};
		s_d.full_s    = {s_q.full_s[0], link.full_reset_in_n};
		s_d.io18_s    = {s_q.io18_s[0], link.io_supply_1v8_ok};
		s_d.cfg_s1    = link.boot_cfg;
		s_d.cfg_s2    = s_q.cfg_s1;
		s_d.full_prev = s_q.full_s[1];
		s_d.cnt       = cfrs_inc(s_q.cnt);
		unique case (s_q.st)
			CFRS_D_POR:
			begin
				if (s_q.por_s[1])
				begin
					s_d.core_n = 1'b1;
					s_d.st     = CFRS_D_HOLD;
				end
			end
			CFRS_D_HOLD:
			begin
				if (s_q.full_s[1] && !s_q.full_prev)
				begin
					// straps stable across the rise, so the delayed copy is safe
					s_d.cfg    = s_q.cfg_s2;
					s_d.fuse_n = 1'b1;
					s_d.st     = CFRS_D_SCAN;
					s_d.cnt    = '0;
				end
			end
			CFRS_D_SCAN:
			begin
				if (s_q.cnt >= CNT_W'(SCAN_CYC - 1))
				begin
					s_d.stat = 1'b1;
					s_d.st   = CFRS_D_DONE;
				end
			end
			CFRS_D_DONE:
				s_d.st = CFRS_D_DONE;
		endcase
		// por low forces CFRS_D_POR; full low after por only forces CFRS_D_HOLD, clearing fuse and status
		if (!s_q.por_s[1])
		begin
			s_d.st     = CFRS_D_POR;
			s_d.core_n = 1'b0;
			s_d.fuse_n = 1'b0;
			s_d.stat   = 1'b0;
		end
		else if (!s_q.full_s[1] && s_q.st != CFRS_D_POR)
		begin
			s_d.st     = CFRS_D_HOLD;
			s_d.fuse_n = 1'b0;
			s_d.stat   = 1'b0;
		end
		if (!s_q.io18_s[1])
			s_d.stat = 1'b0;
		if (!NRST_I)
		begin
			s_d    = '0;
			s_d.st = CFRS_D_POR;
		end
	end

	always_ff @(posedge CLOCK_I)
		s_q <= s_d;

	assign link.reset_status_out = s_q.stat;
	assign BOOT_CFG_O            = s_q.cfg;
	assign FUSE_RESET_N_O        = s_q.fuse_n;
	assign CORE_RESET_N_O        = s_q.core_n;

endmodule // cfrs_dev

// ### cfrs_asserts.sv
// cfrs_asserts: timing checks on the supervisor to device pins.
// assumes one clock and the sync active-low reset of both ends.
`timescale 1ns/1ns
module cfrs_asserts
	import cfrs_pkg::*;
(
	// clock and reset
	input wire logic             CLOCK_I,
	input wire logic             NRST_I,
	// link pins
	input wire logic             core_supply_ok,
	input wire logic             memory_array_supply_ok,
	input wire logic             io_supply_1v8_ok,
	input wire logic             io_supply_1v5_en,
	input wire logic             pll_reference_clock_run,
	input wire logic             memory_reference_clock_run,
	input wire logic             por_n,
	input wire logic             full_reset_in_n,
	input wire logic             warm_reset_n,
	input wire logic [CFG_W-1:0] boot_cfg,
	input wire logic             reset_status_out
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!NRST_I);
	// ----
	// helper counters
	// ----
	logic             all_ok;
	logic [CNT_W-1:0] stab_q;
	logic [CNT_W-1:0] stab_d;
	logic [CNT_W-1:0] scan_q;
	logic [CNT_W-1:0] scan_d;
	assign all_ok = core_supply_ok & memory_array_supply_ok & io_supply_1v8_ok & io_supply_1v5_en;
	always_comb
	begin
		stab_d = all_ok ? stab_q + 24'h00_0001 : 24'h00_0000;
		scan_d = !full_reset_in_n ? 24'h00_0000 : (reset_status_out ? scan_q : scan_q + 24'h00_0001);
	end
	always_ff @(posedge CLOCK_I)
	begin
		stab_q <= NRST_I ? stab_d : 24'h00_0000;
		scan_q <= NRST_I ? scan_d : 24'h00_0000;
	end
	// ----
	// assertions
	// ----
	AST_POR_IN_STAB: assert property (por_n |-> all_ok) else $error("por high before supplies");
	// slack of two covers the flop between state entry and the counter
	AST_POR_WAIT: assert property (
		$rose(por_n) |-> stab_q >= STAB_HOLD_CYC + INIT_WAIT_CYC - 2)
		else $error("por released too early");
	AST_CLK_BEFORE_POR: assert property (
		por_n |-> pll_reference_clock_run && memory_reference_clock_run)
		else $error("por high without clocks");
	AST_FULL_HOLD: assert property (
		$rose(full_reset_in_n) |-> $past(por_n, 24))
		else $error("full reset low too short");
	AST_POR_FIRST: assert property (full_reset_in_n |-> por_n) else $error("full before por");
	AST_CFG_SETUP: assert property (
		$rose(full_reset_in_n) |-> boot_cfg == $past(boot_cfg, 12))
		else $error("straps changed in setup");
	AST_CFG_HOLD: assert property (
		$rose(full_reset_in_n) |-> ##12 boot_cfg == $past(boot_cfg, 12))
		else $error("straps changed in hold");
	AST_STAT_EARLY: assert property (
		$rose(reset_status_out) |-> scan_q >= STAT_MIN_CYC)
		else $error("status too early");
	AST_STAT_LATE: assert property (scan_q <= STAT_MAX_CYC) else $error("status too late");
	AST_STAT_NO_IO: assert property (
		!io_supply_1v8_ok |-> !reset_status_out)
		else $error("status high without io");
	AST_WARM_FIRST: assert property ($rose(por_n) |-> warm_reset_n) else $error("warm low at por");
	AST_CLK_CORE: assert property (
		pll_reference_clock_run |-> core_supply_ok)
		else $error("clock before core");
	AST_IO_ORDER: assert property (io_supply_1v5_en |-> io_supply_1v8_ok) else $error("1v5 before 1v8");
	COV_POR: cover property ($rose(por_n));
	COV_FULL: cover property ($rose(full_reset_in_n));
	COV_STAT: cover property ($rose(reset_status_out));
endmodule // cfrs_asserts

// ### tb.sv
// tb: both ends joined by the link; runs two boots with a reset between.
// assumes the checker watches the link pins.
`timescale 1ns/1ns
module tb;
	import cfrs_pkg::*;
	logic             clk = 1'b0;
	logic             nrst = 1'b0;
	logic             start = 1'b0;
	logic [CNT_W-1:0] extra = 24'h00_0000;
	logic [CFG_W-1:0] cfg = 16'h0000;
	logic             ready;
	logic             tmo;
	logic [CFG_W-1:0] cfg_out;
	logic             fuse_n;
	logic             core_n;
	int               errors = 0;
	int               checks = 0;
	always #4 clk = ~clk;
	cfrs_if link ();
	cfrs_sup u_cfrs_sup (.CLOCK_I(clk), .NRST_I(nrst), .START_I(start), .EXTRA_HOLD_I(extra),
		.BOOT_CFG_I(cfg), .DEVICE_READY_O(ready), .TIMEOUT_O(tmo), .link(link));
	// shortest legal scan keeps the run brief
	cfrs_dev #(.SCAN_CYC(10000)) u_cfrs_dev (.CLOCK_I(clk), .NRST_I(nrst), .BOOT_CFG_O(cfg_out),
		.FUSE_RESET_N_O(fuse_n), .CORE_RESET_N_O(core_n), .link(link));
	cfrs_asserts u_cfrs_asserts (.CLOCK_I(clk), .NRST_I(nrst), .core_supply_ok(link.core_supply_ok),
		.memory_array_supply_ok(link.memory_array_supply_ok), .io_supply_1v8_ok(link.io_supply_1v8_ok),
		.io_supply_1v5_en(link.io_supply_1v5_en), .pll_reference_clock_run(link.pll_reference_clock_run),
		.memory_reference_clock_run(link.memory_reference_clock_run), .por_n(link.por_n),
		.full_reset_in_n(link.full_reset_in_n), .warm_reset_n(link.warm_reset_n),
		.boot_cfg(link.boot_cfg), .reset_status_out(link.reset_status_out));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// counts edges until the chosen level is high, giving up at lim
	task automatic wait_hi(input int sel, input int lim, output int n);
		logic v;
		n = 0;
		v = 1'b0;
		while (v !== 1'b1 && n < lim)
		begin
			@(posedge clk);
			#1;
			n++;
			case (sel)
				0: v = link.por_n;
				1: v = link.full_reset_in_n;
				2: v = fuse_n;
				3: v = link.reset_status_out;
				default: v = ready;
			endcase
		end
		check(v, 1'b1);
	endtask
	task automatic do_reset();
		@(posedge clk);
		nrst <= 1'b0;
		start <= 1'b0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
	endtask
	task automatic run_boot(input logic [15:0] c, input logic [23:0] x);
		int  n;
		time tf;
		@(posedge clk);
		start <= 1'b1;
		extra <= x;
		cfg <= c;
		wait_hi(0, 20000, n);
		check(n >= STAB_HOLD_CYC + INIT_WAIT_CYC, 1'b1);
		check(core_n, 1'b0);
		check({link.warm_reset_n, link.pll_reference_clock_run}, 2'b11);
		// user straps change early: the pins must keep the value taken at por
		@(posedge clk);
		cfg <= ~c;
		wait_hi(1, 1000, n);
		tf = $time;
		check(n >= FULL_LOW_EDGES + int'(x), 1'b1);
		check(core_n, 1'b1);
		check(link.boot_cfg, c);
		wait_hi(2, 20, n);
		check(n <= 8, 1'b1);
		check(cfg_out, c);
		repeat (12 - n) @(posedge clk);
		#1;
		check(link.boot_cfg, c);
		wait_hi(3, 60000, n);
		n = int'(($time - tf) / 8);
		check(n >= STAT_MIN_CYC && n <= STAT_MAX_CYC, 1'b1);
		wait_hi(4, 10, n);
		check(tmo, 1'b0);
	endtask
	task automatic test_extended();
		run_boot(16'hA5C3, 24'h00_0028);
		$display("extended full reset boot done");
	endtask
	// second boot after a mid-run reset, with the shortest full reset
	task automatic test_rerun();
		do_reset();
		#1;
		check(link.reset_status_out, 1'b0);
		run_boot(16'h5A3C, 24'h00_0000);
		$display("rerun after reset done");
	endtask
	initial
	begin
		do_reset();
		test_extended();
		test_rerun();
		test_done();
	end
	initial
	begin
		// two boots need about 50000 cycles; the rest is margin
		repeat (60000) @(posedge clk);
		errors++;
		test_done();
	end
endmodule // tb
